/* hw/irq_status_pkg.sv */
// Purpose: Shared constants and carrier types for the bridge status and interrupt block.
// Assumes: APB with 32-bit data, one word per register.
// Notes: Printed offsets are register indices; byte address is four times the index.
`default_nettype none
package irq_status_pkg;
   // ==================================================================
   // Register map
   // ==================================================================
   localparam logic [7:0] IDX_ENABLE = 8'hC5;
   localparam logic [7:0] IDX_STATUS = 8'hC6;
   localparam logic [7:0] IDX_ERROR = 8'hC7;
   localparam int ADDR_W = 12;
   localparam logic [ADDR_W-1:0] ADDR_ENABLE = {2'h0, IDX_ENABLE, 2'h0};
   localparam logic [ADDR_W-1:0] ADDR_STATUS = {2'h0, IDX_STATUS, 2'h0};
   localparam logic [ADDR_W-1:0] ADDR_ERROR = {2'h0, IDX_ERROR, 2'h0};
   // ==================================================================
   // Field layouts and masks
   // ==================================================================
   localparam int B_CBUF_EMPTY = 15;
   localparam int B_CBUF_ROOM = 14;
   localparam int B_CLK_IDLE = 11;
   localparam int B_DAT_IDLE = 10;
   localparam int B_LBUF_EMPTY = 9;
   localparam int B_LBUF_ROOM = 8;
   localparam int B_PLL_LOCK = 7;
   localparam int B_LP_TIMER = 6;
   localparam int B_HS_TIMER = 5;
   localparam int B_ACK_TRIG = 4;
   localparam int B_ACK_GOT = 3;
   localparam int B_TA_BACK = 2;
   localparam int B_ACCEPT = 1;
   localparam int B_READBACK = 0;
   localparam int B_CRC = 10;
   localparam int B_ECC2 = 9;
   localparam int B_ECC1 = 8;
   localparam int B_OVERRUN = 7;
   localparam int B_COLLIDE = 2;
   localparam int B_VCID = 0;
   localparam logic [15:0] ENABLE_WMASK = 16'hC3EF;
   localparam logic [15:0] ENABLE_RESET = 16'h0080;
   localparam logic [15:0] STATUS_W1C = 16'h0078;
   localparam logic [15:0] ERROR_W1C = 16'h0781;
   localparam logic [15:0] ZERO16 = 16'h0000;
   localparam logic [31:0] ZERO32 = 32'h0000_0000;

   // Events raised by the lane and packet engines, one cycle each.
   typedef struct packed {
      logic lp_rx_expired;
      logic hs_tx_expired;
      logic ack_trigger;
      logic ack_error_report;
      logic turnaround_start;
      logic turnaround_back;
      logic crc_fail;
      logic ecc_multi;
      logic ecc_single;
      logic cmdbuf_overflow;
      logic vcid_mismatch;
   } link_event_t;

   // Levels reported by the surrounding datapath.
   typedef struct packed {
      logic cmdbuf_empty;
      logic cmdbuf_full;
      logic lbuf_empty;
      logic lbuf_full;
      logic clk_lane_lp11;
      logic data_lane_lp11;
      logic pll_locked;
      logic accept_ready;
      logic read_active;
      logic read_data_pending;
      logic contention;
   } link_level_t;
endpackage
`default_nettype wire

/* hw/dsi_bridge_irq_status.sv */
// Purpose: Interrupt enable, interrupt status and error status registers of the display bridge.
// Assumes: Events are one-cycle pulses and levels are synchronous to pclk.
// Notes: Before PLL lock pclk is the reference clock; that is invisible to this logic.
`timescale 1ns/10ps
`default_nettype none

// Behaviour
// - Buffer-empty and buffer-room reach the interrupt only with enable bits 15, 14 (command) and 9, 8 (line).
// - PLL lock, LP receive and HS transmit timers gated by enable bits 7, 6, 5.
// - Ack, turnaround-back, accept-more and readback gated by enable bits 3 to 0.
// - Status bit 15 reads 1 while the command buffer is empty.
// - Status bit 14 reads 1 while the command buffer is not full.
// - Status bits 11 and 10 show clock and data lane in LP-11.
// - Status bit 7 shows PLL lock; device runs on reference clock before it.
// - Status bits 6 and 5 read 0 when timers expired; write 1 clears.
// - Status bit 4 sets on an ack trigger message; write 1 clears.
// - Status bit 3 sets on any ack response; write 1 clears.
// - Status bit 2 is 0 after turnaround until the lane authority returns.
// - Status bit 1 shows whether more host data can be accepted.
// - Status bit 0 shows readback data during a read, clearing when drained.
// - Error bit 10 latches CRC failures when checking enabled; write 1 clears.
// - Error bit 9 latches multi-bit header ECC errors when checking enabled.
// - Error bit 8 latches single-bit header ECC errors when checking enabled.
// - Error bit 7 latches command buffer overflow until written with 1.
// - Error bit 2 follows the data lane contention detector.
// - Error bit 0 sets on a virtual channel identifier mismatch.
module dsi_bridge_irq_status
(
   // Clock and reset.
   input wire logic pclk,
   input wire logic presetn,
   // APB slave.
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [irq_status_pkg::ADDR_W-1:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [3:0] pstrb,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // Datapath conditions.
   input wire irq_status_pkg::link_event_t evt,
   input wire irq_status_pkg::link_level_t lvl,
   input wire logic check_disable,
   // Interrupt pin.
   output logic irq
);
   import irq_status_pkg::*;

   // ==================================================================
   // Bus decode
   // ==================================================================
   logic access;
   logic wr;
   logic hit_en;
   logic hit_st;
   logic hit_er;
   logic [15:0] wdat;
   logic [15:0] lane_mask;
   logic [15:0] enable_q;
   logic [15:0] sticky_q;
   logic [15:0] error_q;
   logic ta_back_q;
   logic [15:0] status_view;
   logic [15:0] error_view;
   logic [15:0] clr_st;
   logic [15:0] clr_er;
   logic [15:0] set_st;
   logic [15:0] set_er;
   logic [15:0] irq_cond;

   // Zero wait states: every access completes on its first access-phase edge.
   assign access = psel & penable;
   assign wr = access & pwrite;
   assign hit_en = (paddr == ADDR_ENABLE);
   assign hit_st = (paddr == ADDR_STATUS);
   assign hit_er = (paddr == ADDR_ERROR);
   assign pready = 1'b1;
   assign pslverr = access & ~(hit_en | hit_st | hit_er);
   // Byte strobes gate the two low lanes; upper lanes hold nothing.
   assign lane_mask = {{8{pstrb[1]}}, {8{pstrb[0]}}};
   assign wdat = pwdata[15:0] & lane_mask;

   // ==================================================================
   // Enable register
   // ==================================================================
   // Reserved bits stay zero because the write mask drops them.
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         enable_q <= ENABLE_RESET;
      else if (wr && hit_en)
         enable_q <= (enable_q & ~(ENABLE_WMASK & lane_mask)) | (wdat & ENABLE_WMASK);
   end

   // ==================================================================
   // Status sticky bits
   // ==================================================================
   assign clr_st = (wr && hit_st) ? (wdat & STATUS_W1C) : ZERO16;
   always_comb
   begin
      set_st = ZERO16;
      set_st[B_ACK_TRIG] = evt.ack_trigger;
      set_st[B_ACK_GOT] = evt.ack_trigger | evt.ack_error_report;
   end

   // Timer bits are stored as expired flags: a stored 1 means the timer ran out,
   // so the status view reads 1 (not expired) after reset and after a clear.
   // Set always beats a same-cycle clear so no event is lost.
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         sticky_q <= ZERO16;
      else
      begin
         sticky_q <= (sticky_q & ~clr_st) | set_st;
         sticky_q[B_LP_TIMER] <= (sticky_q[B_LP_TIMER] & ~clr_st[B_LP_TIMER]) | evt.lp_rx_expired;
         sticky_q[B_HS_TIMER] <= (sticky_q[B_HS_TIMER] & ~clr_st[B_HS_TIMER]) | evt.hs_tx_expired;
      end
   end

   // Lane authority: dropped when a turnaround starts, regained on handback.
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         ta_back_q <= 1'b1;
      else if (evt.turnaround_back)
         ta_back_q <= 1'b1;
      else if (evt.turnaround_start)
         ta_back_q <= 1'b0;
   end

   always_comb
   begin
      status_view = ZERO16;
      status_view[B_CBUF_EMPTY] = lvl.cmdbuf_empty;
      status_view[B_CBUF_ROOM] = ~lvl.cmdbuf_full;
      status_view[B_CLK_IDLE] = lvl.clk_lane_lp11;
      status_view[B_DAT_IDLE] = lvl.data_lane_lp11;
      status_view[B_LBUF_EMPTY] = lvl.lbuf_empty;
      status_view[B_LBUF_ROOM] = ~lvl.lbuf_full;
      status_view[B_PLL_LOCK] = lvl.pll_locked;
      status_view[B_LP_TIMER] = ~sticky_q[B_LP_TIMER];
      status_view[B_HS_TIMER] = ~sticky_q[B_HS_TIMER];
      status_view[B_ACK_TRIG] = sticky_q[B_ACK_TRIG];
      status_view[B_ACK_GOT] = sticky_q[B_ACK_GOT];
      status_view[B_TA_BACK] = ta_back_q;
      status_view[B_ACCEPT] = lvl.accept_ready;
      status_view[B_READBACK] = lvl.read_active & lvl.read_data_pending;
   end

   // ==================================================================
   // Error register
   // ==================================================================
   assign clr_er = (wr && hit_er) ? (wdat & ERROR_W1C) : ZERO16;
   always_comb
   begin
      set_er = ZERO16;
      set_er[B_CRC] = evt.crc_fail & ~check_disable;
      set_er[B_ECC2] = evt.ecc_multi & ~check_disable;
      set_er[B_ECC1] = evt.ecc_single & ~check_disable;
      set_er[B_OVERRUN] = evt.cmdbuf_overflow;
      set_er[B_VCID] = evt.vcid_mismatch;
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         error_q <= ZERO16;
      else
         error_q <= (error_q & ~clr_er) | set_er;
   end

   always_comb
   begin
      error_view = error_q & ERROR_W1C;
      error_view[B_COLLIDE] = lvl.contention;
   end

   // ==================================================================
   // Read data and interrupt
   // ==================================================================
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         prdata <= ZERO32;
      else if (psel && !penable && !pwrite)
      begin
         if (hit_en)
            prdata <= {ZERO16, enable_q};
         else if (hit_st)
            prdata <= {ZERO16, status_view};
         else if (hit_er)
            prdata <= {ZERO16, error_view};
         else
            prdata <= ZERO32;
      end
   end

   // Each enable bit watches the condition under it; timers are conditions while
   // expired, so their stored expired flags are used here. Reserved positions stay zero.
   always_comb
   begin
      irq_cond = status_view & ENABLE_WMASK;
      irq_cond[B_LP_TIMER] = sticky_q[B_LP_TIMER];
      irq_cond[B_HS_TIMER] = sticky_q[B_HS_TIMER];
   end

   // Timer conditions raise the line while expired; registered to keep the pin clean.
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         irq <= 1'b0;
      else
         irq <= |(enable_q & irq_cond);
   end

   // ==================================================================
   // Checks
   // ==================================================================
   property p_empty_irq;
      @(posedge pclk) disable iff (!presetn)
      (enable_q[B_CBUF_EMPTY] && lvl.cmdbuf_empty) |=> irq;
   endproperty
   a_empty_irq: assert property (p_empty_irq) else $error("empty not routed");

   property p_mask_off;
      @(posedge pclk) disable iff (!presetn)
      (enable_q == ZERO16) |=> !irq;
   endproperty
   a_mask_off: assert property (p_mask_off) else $error("irq without enable");

   property p_pll_irq;
      @(posedge pclk) disable iff (!presetn)
      (enable_q == ENABLE_RESET && lvl.pll_locked) |=> irq;
   endproperty
   a_pll_irq: assert property (p_pll_irq) else $error("pll lock not routed");

   property p_ack_sticky;
      @(posedge pclk) disable iff (!presetn)
      evt.ack_trigger |=> (sticky_q[B_ACK_TRIG] && sticky_q[B_ACK_GOT]);
   endproperty
   a_ack_sticky: assert property (p_ack_sticky) else $error("ack flag lost");

   property p_ack_hold;
      @(posedge pclk) disable iff (!presetn)
      (sticky_q[B_ACK_GOT] && !clr_st[B_ACK_GOT]) |=> sticky_q[B_ACK_GOT];
   endproperty
   a_ack_hold: assert property (p_ack_hold) else $error("ack flag dropped");

   property p_timer_expire;
      @(posedge pclk) disable iff (!presetn)
      evt.hs_tx_expired |=> !status_view[B_HS_TIMER];
   endproperty
   a_timer_expire: assert property (p_timer_expire) else $error("timer not expired");

   property p_crc_gate;
      @(posedge pclk) disable iff (!presetn)
      (!error_q[B_CRC] && evt.crc_fail && check_disable) |=> !error_q[B_CRC];
   endproperty
   a_crc_gate: assert property (p_crc_gate) else $error("crc set while disabled");

   property p_overrun;
      @(posedge pclk) disable iff (!presetn)
      evt.cmdbuf_overflow |=> error_q[B_OVERRUN] ##1 (error_q[B_OVERRUN] || $past(clr_er[B_OVERRUN]));
   endproperty
   a_overrun: assert property (p_overrun) else $error("overrun not held");

   property p_turnaround;
      @(posedge pclk) disable iff (!presetn)
      (evt.turnaround_start && !evt.turnaround_back) |=> !status_view[B_TA_BACK];
   endproperty
   a_turnaround: assert property (p_turnaround) else $error("authority not dropped");

   property p_room_irq;
      @(posedge pclk) disable iff (!presetn)
      (enable_q[B_CBUF_ROOM] && !lvl.cmdbuf_full) |=> irq;
   endproperty
   a_room_irq: assert property (p_room_irq) else $error("room not routed");

   property p_timer_irq;
      @(posedge pclk) disable iff (!presetn)
      ((enable_q[B_LP_TIMER] && !status_view[B_LP_TIMER]) || (enable_q[B_HS_TIMER] && !status_view[B_HS_TIMER])) |=> irq;
   endproperty
   a_timer_irq: assert property (p_timer_irq) else $error("timer not routed");

   property p_turn_irq;
      @(posedge pclk) disable iff (!presetn)
      (enable_q[B_TA_BACK] && ta_back_q) |=> irq;
   endproperty
   a_turn_irq: assert property (p_turn_irq) else $error("turnaround not routed");

   property p_read_irq;
      @(posedge pclk) disable iff (!presetn)
      (enable_q[B_READBACK] && lvl.read_active && lvl.read_data_pending) |=> irq;
   endproperty
   a_read_irq: assert property (p_read_irq) else $error("readback not routed");

   property p_quiet_irq;
      @(posedge pclk) disable iff (!presetn)
      ((enable_q & {lvl.cmdbuf_empty, ~lvl.cmdbuf_full, 4'h0, lvl.lbuf_empty, ~lvl.lbuf_full, lvl.pll_locked,
         sticky_q[B_LP_TIMER], sticky_q[B_HS_TIMER], 1'b0, sticky_q[B_ACK_GOT], ta_back_q, lvl.accept_ready,
         lvl.read_active & lvl.read_data_pending}) == ZERO16) |=> !irq;
   endproperty
   a_quiet_irq: assert property (p_quiet_irq) else $error("irq with no enabled condition");

   property p_level_read;
      @(posedge pclk) disable iff (!presetn)
      (psel && penable && !pwrite && hit_st) |-> (prdata[B_CBUF_EMPTY] == $past(lvl.cmdbuf_empty))
         && (prdata[B_CBUF_ROOM] != $past(lvl.cmdbuf_full)) && (prdata[B_CLK_IDLE] == $past(lvl.clk_lane_lp11))
         && (prdata[B_DAT_IDLE] == $past(lvl.data_lane_lp11)) && (prdata[B_PLL_LOCK] == $past(lvl.pll_locked))
         && (prdata[B_ACCEPT] == $past(lvl.accept_ready));
   endproperty
   a_level_read: assert property (p_level_read) else $error("level bits misread");

   property p_readback_read;
      @(posedge pclk) disable iff (!presetn)
      (psel && penable && !pwrite && hit_st && !$past(lvl.read_active)) |-> !prdata[B_READBACK];
   endproperty
   a_readback_read: assert property (p_readback_read) else $error("readback outside a read");

   property p_ack_err;
      @(posedge pclk) disable iff (!presetn)
      evt.ack_error_report |=> sticky_q[B_ACK_GOT];
   endproperty
   a_ack_err: assert property (p_ack_err) else $error("error report not seen");

   property p_ack_only;
      @(posedge pclk) disable iff (!presetn)
      (evt.ack_error_report && !evt.ack_trigger && !sticky_q[B_ACK_TRIG]) |=> !sticky_q[B_ACK_TRIG];
   endproperty
   a_ack_only: assert property (p_ack_only) else $error("trigger flag on error report");

   property p_ta_back;
      @(posedge pclk) disable iff (!presetn)
      evt.turnaround_back |=> status_view[B_TA_BACK];
   endproperty
   a_ta_back: assert property (p_ta_back) else $error("authority not regained");

   property p_crc_set;
      @(posedge pclk) disable iff (!presetn)
      (evt.crc_fail && !check_disable) |=> error_q[B_CRC];
   endproperty
   a_crc_set: assert property (p_crc_set) else $error("crc not latched");

   property p_ecc2_set;
      @(posedge pclk) disable iff (!presetn)
      (evt.ecc_multi && !check_disable) |=> error_q[B_ECC2];
   endproperty
   a_ecc2_set: assert property (p_ecc2_set) else $error("multi-bit error not latched");

   property p_ecc1_set;
      @(posedge pclk) disable iff (!presetn)
      (evt.ecc_single && !check_disable) |=> error_q[B_ECC1];
   endproperty
   a_ecc1_set: assert property (p_ecc1_set) else $error("single-bit error not latched");

   property p_collide_read;
      @(posedge pclk) disable iff (!presetn)
      (psel && penable && !pwrite && hit_er) |-> (prdata[B_COLLIDE] == $past(lvl.contention));
   endproperty
   a_collide_read: assert property (p_collide_read) else $error("contention misread");

   property p_vcid;
      @(posedge pclk) disable iff (!presetn)
      evt.vcid_mismatch |=> error_q[B_VCID];
   endproperty
   a_vcid: assert property (p_vcid) else $error("channel mismatch not latched");

   property p_timer_clear;
      @(posedge pclk) disable iff (!presetn)
      (clr_st[B_HS_TIMER] && !evt.hs_tx_expired) |=> status_view[B_HS_TIMER];
   endproperty
   a_timer_clear: assert property (p_timer_clear) else $error("timer flag not cleared");
endmodule // dsi_bridge_irq_status
`default_nettype wire

/* testbench/host_apb_model.sv */
// Purpose: Behavioural host processor that issues APB transfers to the status block.
// Assumes: The slave may add wait states; pready is sampled at rising edges.
// Notes: Transfers are spaced out until the host has read PLL lock as 1.
`timescale 1ns/10ps
`default_nettype none
module host_apb_model
   import irq_status_pkg::*;
#(parameter int SLOW_GAP = 3)
(
   // Clock.
   input wire logic pclk,
   // APB master side.
   output logic psel,
   output logic penable,
   output logic pwrite,
   output logic [ADDR_W-1:0] paddr,
   output logic [31:0] pwdata,
   output logic [3:0] pstrb,
   input wire logic [31:0] prdata,
   input wire logic pready,
   input wire logic pslverr
);
   logic lock_seen = 1'b0;
   // ==================================================================
   // Transfers
   // ==================================================================
   // The bus idles low from time zero.
   initial
   begin
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = '0;
      pwdata = ZERO32;
      pstrb = 4'hF;
   end
   // One transfer; the request is held until pready is seen high.
   task automatic xfer(input logic w, input logic [ADDR_W-1:0] a, input logic [31:0] d,
                       output logic [31:0] r, output logic e);
      if (!lock_seen)
      begin
         repeat (SLOW_GAP) @(posedge pclk);
      end
      @(posedge pclk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      @(posedge pclk);
      while (pready !== 1'b1)
      begin
         @(posedge pclk);
      end
      r = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      pwdata <= ~d;
      // Full speed is safe only once the PLL drives the clock.
      if (!w && a == ADDR_STATUS && r[B_PLL_LOCK] === 1'b1)
      begin
         lock_seen = 1'b1;
      end
   endtask
endmodule // host_apb_model
`default_nettype wire

/* testbench/tb_top.sv */
// Purpose: Self-checking bench for the status and interrupt block.
// Assumes: Zero-wait APB slave; events are one-cycle pulses.
// Notes: Expected register values are worked out by hand per step.
`timescale 1ns/10ps
`default_nettype none
module tb_top;
   import irq_status_pkg::*;
   logic pclk, presetn, psel, penable, pwrite, pready, pslverr, check_disable, irq;
   logic [ADDR_W-1:0] paddr;
   logic [31:0] pwdata, prdata;
   logic [3:0] pstrb;
   link_event_t evt;
   link_level_t lvl;
   int bad_count = 0;
   int n_tests = 0;
   int cycles = 0;
   // ==================================================================
   // Clock, timeout and instances
   // ==================================================================
   initial pclk = 1'b0;
   always #2 pclk = ~pclk;
   // A hang counts as a mismatch.
   always @(posedge pclk)
   begin
      cycles++;
      if (cycles == 20000)
      begin
         bad_count++;
         tally_and_finish();
      end
   end
   dsi_bridge_irq_status dsi_bridge_irq_status_inst (.pclk(pclk), .presetn(presetn), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .evt(evt), .lvl(lvl), .check_disable(check_disable), .irq(irq));
   host_apb_model host_apb_model_inst (.pclk(pclk), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr));
   // ==================================================================
   // Helpers
   // ==================================================================
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_tests++;
      if (got !== exp)
      begin
         bad_count++;
         $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic rd(input logic [ADDR_W-1:0] a, input logic [15:0] exp);
      logic [31:0] r;
      logic e;
      host_apb_model_inst.xfer(1'b0, a, ZERO32, r, e);
      chk(r, {16'h0000, exp});
   endtask
   task automatic wr(input logic [ADDR_W-1:0] a, input logic [15:0] d);
      logic [31:0] r;
      logic e;
      host_apb_model_inst.xfer(1'b1, a, {16'h0000, d}, r, e);
   endtask
   task automatic pulse(input link_event_t e);
      @(posedge pclk);
      evt <= e;
      @(posedge pclk);
      evt <= '0;
   endtask
   // Enables one source at a time; irq must follow that source alone.
   task automatic sweep(input logic [15:0] cond);
      for (int i = 0; i < 16; i++)
      begin
         if (ENABLE_WMASK[i])
         begin
            wr(ADDR_ENABLE, 16'h0001 << i);
            repeat (3) @(posedge pclk);
            chk({31'h0, irq}, {31'h0, cond[i]});
         end
      end
   endtask
   task automatic tally_and_finish();
      $display("comparisons=%0d mismatches=%0d", n_tests, bad_count);
      if (bad_count == 0 && n_tests > 0)
      begin
         $display("No errors found");
      end
      else
      begin
         $display("Errors were found");
      end
      $finish;
   endtask
   // ==================================================================
   // Tests
   // ==================================================================
   initial
   begin
      logic [31:0] r;
      logic e;
      presetn = 1'b0;
      evt = '0;
      lvl = 11'h568;
      check_disable = 1'b0;
      repeat (5) @(posedge pclk);
      presetn <= 1'b1;
      // Reset values, and a refused access to an unmapped word.
      rd(ADDR_ENABLE, 16'h0080);
      rd(ADDR_STATUS, 16'hCF66);
      rd(ADDR_ERROR, 16'h0000);
      chk({31'h0, irq}, 32'h0);
      host_apb_model_inst.xfer(1'b0, '0, ZERO32, r, e);
      chk({r[30:0], e}, 32'h1);
      $display("test reset done");
      // Enable mask and per-source routing.
      wr(ADDR_ENABLE, 16'hFFFF);
      rd(ADDR_ENABLE, 16'hC3EF);
      sweep(16'hCF06);
      $display("test routing done");
      // Levels flipped: full buffers, lanes busy, PLL locked, read pending.
      lvl <= 11'h297;
      rd(ADDR_STATUS, 16'h00E5);
      rd(ADDR_ERROR, 16'h0004);
      lvl.read_data_pending <= 1'b0;
      rd(ADDR_STATUS, 16'h00E4);
      $display("test levels done");
      // Sticky events and write-one-to-clear.
      pulse(11'h600);
      rd(ADDR_STATUS, 16'h0084);
      sweep(16'h00E4);
      wr(ADDR_ENABLE, 16'h0000);
      repeat (2) @(posedge pclk);
      chk({31'h0, irq}, 32'h0);
      pulse(11'h100);
      rd(ADDR_STATUS, 16'h009C);
      wr(ADDR_STATUS, 16'h0018);
      pulse(11'h080);
      rd(ADDR_STATUS, 16'h008C);
      pulse(11'h040);
      rd(ADDR_STATUS, 16'h0088);
      pulse(11'h020);
      wr(ADDR_STATUS, 16'h0068);
      rd(ADDR_STATUS, 16'h00E4);
      $display("test events done");
      // Error flags latch until cleared; contention follows its detector.
      pulse(11'h01F);
      rd(ADDR_ERROR, 16'h0785);
      wr(ADDR_ERROR, 16'h0781);
      rd(ADDR_ERROR, 16'h0004);
      lvl.contention <= 1'b0;
      rd(ADDR_ERROR, 16'h0000);
      // With checking disabled, header and checksum errors must not latch.
      check_disable <= 1'b1;
      pulse(11'h01C);
      rd(ADDR_ERROR, 16'h0000);
      check_disable <= 1'b0;
      $display("test errors done");
      tally_and_finish();
   end
endmodule // tb_top
`default_nettype wire
